// >>> rtl/bridge_steer_pkg.sv
// shared types and constants for the enhanced bridge steering stage
`default_nettype none
package bridge_steer_pkg;

   // steering modes, codes as on the mode select pins
   typedef enum logic [1:0] {
      MODE_OFF  = 2'h0,
      MODE_FWD  = 2'h1,
      MODE_HALF = 2'h2,
      MODE_REV  = 2'h3
   } bridge_mode_t;

   // one bit per bridge output
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } bridge_pins_t;

   // shutdown drive choice for one output pair
   typedef struct packed {
      logic drive_b;  // low while the pair is driven
      logic level;
   } pair_drive_t;

   // polarity select bits, a one selects active-low
   localparam int POL_AC_BIT = 1;
   localparam int POL_BD_BIT = 0;

   // shutdown state field codes
   localparam logic [1:0] SD_STATE_LOW = 2'h0;
   localparam logic [1:0] SD_STATE_HIGH = 2'h1;
   localparam int SD_STATE_TRI_BIT = 1;

   // source select field bit positions
   localparam int SRC_CMP1_BIT = 0;
   localparam int SRC_CMP2_BIT = 1;
   localparam int SRC_INT_BIT = 2;

   // direction preamble length in period timer counts
   localparam int PREAMBLE_COUNTS = 4;

   // documented widths
   localparam int DEADBAND_W = 7;
   localparam int TIMER_W = 8;

   // output enable levels (low enables the driver)
   localparam logic OE_DRIVE = 1'b0;
   localparam logic OE_FLOAT = 1'b1;

   // reset values
   localparam bridge_pins_t PINS_RESET = 4'h0;
   localparam bridge_pins_t OE_RESET = 4'hF;

endpackage
`default_nettype wire

// >>> rtl/bridge_steering.sv
// bridge output steering: half/full bridge, dead-band, polarity, shutdown
//
// Overview of operation
// [RULE1] half bridge: pwm on A, complement on B
// [RULE2] half bridge: dead-band delays each output's activation
// [RULE3] dead-band longer than pulse keeps output inactive
// [RULE4] forward: A active, D modulated, B C inactive
// [RULE5] reverse: C active, B modulated, A D inactive
// [RULE6] direction change applies from next pwm cycle
// [RULE7] four counts early: B D off, A C swap
// [RULE8] modulation resumes on new output at next period
// [RULE9] no dead-band in full bridge mode
// [RULE10] firmware may change direction anywhere in period
// [RULE11] firmware lowers duty before reversing near full
// [RULE12] firmware sets used pins' port direction to output
// [RULE13] two polarity bits, one per output pair
// [RULE14] firmware sets polarity before enabling drivers
// [RULE15] firmware waits one full cycle before driving
// [RULE16] period flag raised as second period begins
// [RULE17] source select picks shutdown trigger events
// [RULE18] firmware setting status bit forces shutdown
// [RULE19] status reads 0 running, 1 shut down
// [RULE20] status stays set until cleared or restarted
// [RULE21] shutdown forces outputs without waiting
// [RULE22] each pair driven high, low or floated
// [RULE23] state field: 00 low, 01 high, 1x float
// [RULE24] source codes: comparators, pin, combinations
// [RULE25] shutdown is level based, clears ignored meanwhile
// [RULE26] after restart, output resumes at next period
// [RULE27] all levels pass through pair polarity; the shutdown levels bypass it here
`default_nettype none
module bridge_steering
   import bridge_steer_pkg::*;
#(
   parameter int DB_W = DEADBAND_W,
   parameter int TMR_W = TIMER_W
) (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic PWM_I,
   input wire logic PERIOD_START_I,
   input wire logic [TMR_W-1:0] TIMER_COUNT_I,
   input wire logic [TMR_W-1:0] PERIOD_VALUE_I,
   input wire logic [1:0] BRIDGE_MODE_I,
   input wire logic [1:0] PAIR_POLARITY_SELECT_I,
   input wire logic [DB_W-1:0] DEADBAND_COUNT_I,
   input wire logic [2:0] SHUTDOWN_SOURCE_SELECT_I,
   input wire logic [1:0] PAIR_AC_SHUTDOWN_STATE_I,
   input wire logic [1:0] PAIR_BD_SHUTDOWN_STATE_I,
   input wire logic AUTO_RESTART_ENABLE_I,
   input wire logic STATUS_SET_I,
   input wire logic STATUS_CLEAR_I,
   input wire logic EXT_INT_PIN_I,
   input wire logic COMPARATOR_ONE_I,
   input wire logic COMPARATOR_TWO_I,
   output var bridge_pins_t BRIDGE_OUT_O,
   output var bridge_pins_t BRIDGE_OE_B_O,
   output logic SHUTDOWN_EVENT_STATUS_O,
   output logic PERIOD_TIMER_FLAG_O,
   output logic FIRST_CYCLE_DONE_O
);

   // elaboration-time guard on widths the logic cannot serve
   if (DB_W < 1 || DB_W > 16) begin : g_bad_db
      $error("deadband width out of range");
   end
   if (TMR_W < 3 || TMR_W > 16) begin : g_bad_tmr
      $error("timer width out of range");
   end

   // decode a two-bit shutdown state field into drive and level
   function automatic pair_drive_t pair_state(input logic [1:0] f);
      pair_drive_t r;
      r.drive_b = f[SD_STATE_TRI_BIT] ? OE_FLOAT : OE_DRIVE; // [RULE23]
      r.level = (f == SD_STATE_HIGH); // [RULE23]
      return r;
   endfunction

   // true one count ahead of the last PREAMBLE_COUNTS counts, so the
   // registered preamble covers exactly those last counts
   function automatic logic near_end(input logic [TMR_W-1:0] cnt,
                                     input logic [TMR_W-1:0] per);
      logic [TMR_W:0] sum;
      sum = {1'b0, cnt} + (TMR_W+1)'(PREAMBLE_COUNTS);
      return sum >= {1'b0, per};
   endfunction

   bridge_mode_t mode;
   assign mode = bridge_mode_t'(BRIDGE_MODE_I);

   // ---------------- pin synchronisers
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] next_sync_a;
   logic int_low;
   logic cmp1;
   logic cmp2;

   // raw pins pass two flops; only stage b is read by logic
   always_comb begin
      next_sync_a = {EXT_INT_PIN_I, COMPARATOR_ONE_I, COMPARATOR_TWO_I};
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= sync_a;
      end
   end

   assign int_low = !sync_b[2];
   assign cmp1 = sync_b[1];
   assign cmp2 = sync_b[0];

   // ---------------- shutdown status
   logic status;
   logic hold_off;
   logic next_status;
   logic next_hold_off;
   logic cond;

   // each selected source contributes; 000 disables all
   always_comb begin
      cond = (SHUTDOWN_SOURCE_SELECT_I[SRC_CMP1_BIT] && cmp1) // [RULE24]
          || (SHUTDOWN_SOURCE_SELECT_I[SRC_CMP2_BIT] && cmp2) // [RULE17]
          || (SHUTDOWN_SOURCE_SELECT_I[SRC_INT_BIT] && int_low);
   end

   // set beats clear; a clear is ignored while the condition lasts
   always_comb begin
      next_status = status;
      if (cond || STATUS_SET_I) begin
         next_status = 1'b1; // [RULE18] [RULE20]
      end else if (STATUS_CLEAR_I || AUTO_RESTART_ENABLE_I) begin
         next_status = 1'b0; // [RULE25]
      end
      // outputs stay parked after clearing until the next period edge
      next_hold_off = hold_off;
      if (next_status) begin
         next_hold_off = 1'b1;
      end else if (PERIOD_START_I) begin
         next_hold_off = 1'b0; // [RULE26]
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         status <= 1'b0;
         hold_off <= 1'b0;
      end else begin
         status <= next_status;
         hold_off <= next_hold_off;
      end
   end

   assign SHUTDOWN_EVENT_STATUS_O = status; // [RULE19]

   // ---------------- dead-band counters (half bridge only)
   logic [DB_W-1:0] cnt_a;
   logic [DB_W-1:0] cnt_b;
   logic [DB_W-1:0] next_cnt_a;
   logic [DB_W-1:0] next_cnt_b;

   // count cycles since each output's turn began, saturating
   always_comb begin
      next_cnt_a = '0;
      next_cnt_b = '0;
      if (PWM_I && cnt_a != '1) begin
         next_cnt_a = cnt_a + DB_W'(1);
      end else if (PWM_I) begin
         next_cnt_a = cnt_a;
      end
      if (!PWM_I && cnt_b != '1) begin
         next_cnt_b = cnt_b + DB_W'(1);
      end else if (!PWM_I) begin
         next_cnt_b = cnt_b;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         cnt_a <= '0;
         cnt_b <= '0;
      end else begin
         cnt_a <= next_cnt_a;
         cnt_b <= next_cnt_b;
      end
   end

   // ---------------- direction change sequencing
   logic dir_cur;      // direction used for modulation, 1 = reverse
   logic dir_new;
   logic preamble;
   logic next_dir_cur;
   logic next_dir_new;
   logic next_preamble;
   logic full;
   logic req_dir;

   assign full = (mode == MODE_FWD) || (mode == MODE_REV);
   assign req_dir = (mode == MODE_REV);

   // the request may land anytime; it only acts near the period end
   always_comb begin
      next_dir_cur = dir_cur;
      next_dir_new = dir_new;
      next_preamble = preamble;
      if (!full) begin
         next_dir_cur = req_dir;
         next_preamble = 1'b0;
      end else if (PERIOD_START_I) begin
         next_dir_cur = preamble ? dir_new : dir_cur; // [RULE6] [RULE8]
         next_preamble = 1'b0;
      end else if (!preamble && req_dir != dir_cur
                   && near_end(TIMER_COUNT_I, PERIOD_VALUE_I)) begin
         next_preamble = 1'b1; // [RULE7] [RULE10]
         next_dir_new = req_dir;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         dir_cur <= 1'b0;
         dir_new <= 1'b0;
         preamble <= 1'b0;
      end else begin
         dir_cur <= next_dir_cur;
         dir_new <= next_dir_new;
         preamble <= next_preamble;
      end
   end

   // ---------------- steering into active/inactive terms
   bridge_pins_t act;
   bridge_pins_t used;
   logic unmod_dir;
   logic quiet;
   logic live_dir;

   assign unmod_dir = preamble ? dir_new : dir_cur;
   // the period start cycle already belongs to the new direction, so
   // the first pulse of the new period is not cut short
   assign live_dir = (preamble && PERIOD_START_I) ? dir_new : dir_cur;
   assign quiet = preamble && !PERIOD_START_I;

   always_comb begin
      act = PINS_RESET;
      used = PINS_RESET;
      unique case (mode)
         MODE_OFF: begin
            act = PINS_RESET;
         end
         MODE_HALF: begin
            used = 4'hC;
            // an output waits its dead-band; short pulses never show
            act.a = PWM_I && cnt_a >= DEADBAND_COUNT_I; // [RULE1] [RULE2]
            act.b = !PWM_I && cnt_b >= DEADBAND_COUNT_I; // [RULE3]
         end
         MODE_FWD, MODE_REV: begin
            used = 4'hF;
            // no dead-band here; drivers must tolerate the swap
            act.a = !unmod_dir; // [RULE4] [RULE9]
            act.c = unmod_dir; // [RULE5]
            act.d = !quiet && !live_dir && PWM_I; // [RULE7] [RULE8]
            act.b = !quiet && live_dir && PWM_I; // [RULE7] [RULE8]
         end
      endcase
   end

   // ---------------- registered pin levels with polarity
   bridge_pins_t pins;
   bridge_pins_t oe;
   bridge_pins_t next_pins;
   bridge_pins_t next_oe;
   bridge_pins_t inv;

   always_comb begin
      inv.a = PAIR_POLARITY_SELECT_I[POL_AC_BIT]; // [RULE13]
      inv.c = PAIR_POLARITY_SELECT_I[POL_AC_BIT];
      inv.b = PAIR_POLARITY_SELECT_I[POL_BD_BIT];
      inv.d = PAIR_POLARITY_SELECT_I[POL_BD_BIT];
      next_pins = act ^ inv; // [RULE27]
      next_oe = ~used;
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         pins <= PINS_RESET;
         oe <= OE_RESET;
      end else begin
         pins <= next_pins;
         oe <= next_oe;
      end
   end

   // shutdown overrides the registered levels combinationally so the
   // pins park the moment the condition is seen, not a cycle later
   pair_drive_t sd_ac;
   pair_drive_t sd_bd;
   logic park;

   assign sd_ac = pair_state(PAIR_AC_SHUTDOWN_STATE_I);
   assign sd_bd = pair_state(PAIR_BD_SHUTDOWN_STATE_I);
   assign park = cond || STATUS_SET_I || status || hold_off;

   always_comb begin
      BRIDGE_OUT_O = pins;
      BRIDGE_OE_B_O = oe;
      if (park) begin
         // only enabled pins are forced; unused ones stay floating
         BRIDGE_OUT_O.a = sd_ac.level; // [RULE21] [RULE22]
         BRIDGE_OUT_O.c = sd_ac.level;
         BRIDGE_OUT_O.b = sd_bd.level;
         BRIDGE_OUT_O.d = sd_bd.level;
         BRIDGE_OE_B_O.a = oe.a | sd_ac.drive_b;
         BRIDGE_OE_B_O.c = oe.c | sd_ac.drive_b;
         BRIDGE_OE_B_O.b = oe.b | sd_bd.drive_b;
         BRIDGE_OE_B_O.d = oe.d | sd_bd.drive_b;
      end
   end

   // ---------------- period flag and first-cycle indication
   logic flag;
   logic seen_start;
   logic done;
   logic next_flag;
   logic next_seen_start;
   logic next_done;

   // done rises as the second period after enabling begins
   always_comb begin
      next_flag = PERIOD_START_I && mode != MODE_OFF; // [RULE16]
      next_seen_start = seen_start;
      next_done = done;
      if (mode == MODE_OFF) begin
         next_seen_start = 1'b0;
         next_done = 1'b0;
      end else if (PERIOD_START_I) begin
         next_seen_start = 1'b1;
         next_done = seen_start; // [RULE16]
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         flag <= 1'b0;
         seen_start <= 1'b0;
         done <= 1'b0;
      end else begin
         flag <= next_flag;
         seen_start <= next_seen_start;
         done <= next_done;
      end
   end

   assign PERIOD_TIMER_FLAG_O = flag;
   assign FIRST_CYCLE_DONE_O = done;

   // ---------------- checks
   a_half_complement: assert property (@(posedge CLOCK_I) // [RULE1]
      disable iff (!RST_B_I) mode == MODE_HALF |-> !(act.a && act.b))
      else $error("half bridge outputs active together");

   a_deadband_wait: assert property (@(posedge CLOCK_I) // [RULE2]
      disable iff (!RST_B_I)
      mode == MODE_HALF && act.a |-> PWM_I && cnt_a >= DEADBAND_COUNT_I)
      else $error("output A active before dead-band");

   a_forward_drive: assert property (@(posedge CLOCK_I) // [RULE4]
      disable iff (!RST_B_I)
      full && !dir_cur && !preamble |-> act.a && !act.b && !act.c)
      else $error("forward steering wrong");

   a_reverse_drive: assert property (@(posedge CLOCK_I) // [RULE5]
      disable iff (!RST_B_I)
      full && dir_cur && !preamble |-> act.c && !act.a && !act.d)
      else $error("reverse steering wrong");

   a_preamble_quiet: assert property (@(posedge CLOCK_I) // [RULE7]
      disable iff (!RST_B_I)
      preamble && full && !PERIOD_START_I
      |-> !act.b && !act.d && act.c == dir_new)
      else $error("modulated outputs live in preamble");

   a_resume_start: assert property (@(posedge CLOCK_I) // [RULE8]
      disable iff (!RST_B_I)
      preamble && full && PERIOD_START_I
      |-> act.b == (dir_new && PWM_I) && act.d == (!dir_new && PWM_I))
      else $error("modulation not resumed at period start");

   a_dir_deferred: assert property (@(posedge CLOCK_I) // [RULE6]
      disable iff (!RST_B_I)
      full && $past(full) && !$past(PERIOD_START_I) |-> $stable(dir_cur))
      else $error("direction changed mid period");

   a_status_sets: assert property (@(posedge CLOCK_I) // [RULE20]
      disable iff (!RST_B_I) cond || STATUS_SET_I |=> status)
      else $error("status not set by condition");

   a_status_holds: assert property (@(posedge CLOCK_I) // [RULE20]
      disable iff (!RST_B_I)
      status && !STATUS_CLEAR_I && !AUTO_RESTART_ENABLE_I |=> status)
      else $error("status dropped without a clear");

   a_clear_ignored: assert property (@(posedge CLOCK_I) // [RULE25]
      disable iff (!RST_B_I) cond && STATUS_CLEAR_I |=> status)
      else $error("clear accepted during condition");

   a_shutdown_low: assert property (@(posedge CLOCK_I) // [RULE22]
      disable iff (!RST_B_I)
      status && PAIR_AC_SHUTDOWN_STATE_I == SD_STATE_LOW
      |-> !BRIDGE_OUT_O.a && !BRIDGE_OUT_O.c)
      else $error("pair AC not parked low");

endmodule
`default_nettype wire

// >>> tb/bridge_driver_model.sv
// board-side switch driver model: pull-downs and leg overlap watch
`default_nettype none
module bridge_driver_model
   import bridge_steer_pkg::*;
(
   input wire logic clk_i,
   input wire bridge_pins_t out_i,
   input wire bridge_pins_t oe_b_i,
   input wire logic [1:0] pol_i,
   output var bridge_pins_t pin_o,
   output logic shoot_o
);
   timeunit 1ns;
   timeprecision 100ps;
   bridge_pins_t on;
   logic shoot = 1'h0;
   // a floated pin falls to its pull-down, so a switch never floats on
   assign pin_o = out_i & ~oe_b_i;
   assign on = (pin_o ^ {pol_i[1], pol_i[0], pol_i[1], pol_i[0]}) & ~oe_b_i;
   // legs are a/b and c/d; both switches on shorts the supply
   always @(posedge clk_i) begin
      if ((on.a && on.b) || (on.c && on.d)) shoot <= 1'h1;
   end
   assign shoot_o = shoot;
endmodule
`default_nettype wire

// >>> tb/bridge_steering_tb_top.sv
// self-checking bench for the bridge steering stage
`default_nettype none
module bridge_steering_tb_top
   import bridge_steer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0, rst_b = 1'h0, pwm = 1'h0, pstart = 1'h0;
   logic [7:0] tcount = 8'h00, per = 8'h0F, duty = 8'h06;
   logic [1:0] mode = 2'h0, pol = 2'h0, sac = 2'h0, sbd = 2'h0;
   logic [6:0] db = 7'h00;
   logic [2:0] src = 3'h0;
   logic arst = 1'h0, sset = 1'h0, sclr = 1'h0;
   logic intp = 1'h1, cmp1 = 1'h0, cmp2 = 1'h0;
   logic status, pflag, fdone, shoot;
   bridge_pins_t out, oe_b, pin;
   int n_mismatch = 0, tests_run = 0;

   bridge_steering dut (
      .CLOCK_I(clk),
      .RST_B_I(rst_b),
      .PWM_I(pwm),
      .PERIOD_START_I(pstart),
      .TIMER_COUNT_I(tcount),
      .PERIOD_VALUE_I(per),
      .BRIDGE_MODE_I(mode),
      .PAIR_POLARITY_SELECT_I(pol),
      .DEADBAND_COUNT_I(db),
      .SHUTDOWN_SOURCE_SELECT_I(src),
      .PAIR_AC_SHUTDOWN_STATE_I(sac),
      .PAIR_BD_SHUTDOWN_STATE_I(sbd),
      .AUTO_RESTART_ENABLE_I(arst),
      .STATUS_SET_I(sset),
      .STATUS_CLEAR_I(sclr),
      .EXT_INT_PIN_I(intp),
      .COMPARATOR_ONE_I(cmp1),
      .COMPARATOR_TWO_I(cmp2),
      .BRIDGE_OUT_O(out),
      .BRIDGE_OE_B_O(oe_b),
      .SHUTDOWN_EVENT_STATUS_O(status),
      .PERIOD_TIMER_FLAG_O(pflag),
      .FIRST_CYCLE_DONE_O(fdone)
   );

   bridge_driver_model board (
      .clk_i(clk),
      .out_i(out),
      .oe_b_i(oe_b),
      .pol_i(pol),
      .pin_o(pin),
      .shoot_o(shoot)
   );

   always #12.5 clk = ~clk;

   // period timer and duty compare; duty is six of sixteen counts
   always @(posedge clk) begin
      if (tcount == per) tcount <= 8'h00;
      else tcount <= tcount + 8'h01;
      pstart <= (tcount == per);
      pwm <= (tcount == per) || (tcount + 8'h01 < duty);
   end

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // driven outputs at their active level, a to d
   function automatic logic [3:0] act();
      return (out ^ {pol[1], pol[0], pol[1], pol[0]}) & ~oe_b;
   endfunction

   task automatic wait_start();
      @(negedge clk);
      for (int i = 0; i < 40 && pstart !== 1'h1; i++) @(negedge clk);
   endtask

   task automatic wait_count(input logic [7:0] v);
      @(negedge clk);
      for (int i = 0; i < 40 && tcount !== v; i++) @(negedge clk);
   endtask

   task automatic pulse_clr();
      @(posedge clk) sclr <= 1'h1;
      @(posedge clk) sclr <= 1'h0;
      @(negedge clk);
   endtask

   // active cycles per output over one period, one byte each
   task automatic measure(output logic [31:0] n);
      logic [3:0] a;
      n = 32'h0;
      repeat (16) begin
         @(negedge clk);
         a = act();
         n = n + {7'h0, a[3], 7'h0, a[2], 7'h0, a[1], 7'h0, a[0]};
      end
   endtask

   // float the pins before polarity moves, then let periods complete
   task automatic setup(input logic [1:0] m, p, input logic [6:0] d);
      @(posedge clk) mode <= MODE_OFF;
      repeat (2) @(posedge clk);
      pol <= p;
      db <= d;
      @(posedge clk) mode <= m;
      repeat (3) wait_start();
   endtask

   task automatic t_flags();
      @(posedge clk) mode <= MODE_OFF;
      wait_start();
      @(negedge clk);
      chk("flags off", 32'h0, {pflag, fdone});
      @(posedge clk) mode <= MODE_HALF;
      wait_start();
      @(negedge clk);
      chk("first period", 32'h2, {pflag, fdone});
      wait_start();
      @(negedge clk);
      chk("second period", 32'h3, {pflag, fdone});
   endtask

   task automatic t_half(input logic [6:0] d, input logic [1:0] p);
      logic [31:0] n;
      logic [7:0] ea, eb;
      setup(MODE_HALF, p, d);
      ea = (8'(d) >= duty) ? 8'h00 : duty - 8'(d);
      eb = (8'(d) >= 8'h10 - duty) ? 8'h00 : 8'h10 - duty - 8'(d);
      measure(n);
      chk("half counts", {ea, eb, 16'h0}, n);
   endtask

   task automatic t_full(input logic rev, input logic [1:0] p);
      logic [31:0] n;
      setup(rev ? MODE_REV : MODE_FWD, p, 7'h05);
      measure(n);
      if (rev) chk("rev counts", {8'h0, duty, 16'h1000}, n);
      else chk("fwd counts", {24'h100000, duty}, n);
   endtask

   // reverse mid-period, then watch the preamble and the new period
   task automatic t_dir();
      logic [31:0] n;
      setup(MODE_FWD, 2'h0, 7'h00);
      @(posedge clk) mode <= MODE_REV;
      wait_count(8'h08);
      chk("dir held", 32'h8, act());
      wait_count(8'h0C);
      chk("pre preamble", 32'h8, act());
      wait_count(8'h0D);
      chk("preamble start", 32'h2, act());
      wait_count(per);
      chk("preamble", 32'h2, act());
      wait_count(8'h01);
      chk("resume", 32'h6, act());
      repeat (2) wait_start();
      measure(n);
      chk("new dir", {8'h0, duty, 16'h1000}, n);
   endtask

   task automatic t_sd();
      logic [7:0] e;
      setup(MODE_FWD, 2'h0, 7'h00);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         sac <= 2'(i);
         sbd <= 2'(i + 1);
         src <= 3'h1;
         cmp1 <= 1'h1;
         @(negedge clk);
         for (int j = 0; j < 10 && status !== 1'h1; j++) @(negedge clk);
         e = {sac[1], sbd[1], sac[1], sbd[1], sac == 2'h1, sbd == 2'h1,
            sac == 2'h1, sbd == 2'h1};
         chk("sd pins", e, {oe_b, pin});
         chk("sd status", 32'h1, status);
         pulse_clr();
         chk("clear ignored", 32'h1, status);
         @(posedge clk) cmp1 <= 1'h0;
         wait_count(8'h03);
         chk("sd latched", 32'h1, status);
         pulse_clr();
         chk("sd cleared", 32'h0, status);
         chk("still parked", e, {oe_b, pin});
      end
      wait_start();
      repeat (2) @(negedge clk);
      chk("restart", 32'h9, act());
      @(posedge clk) src <= 3'h0;
      @(posedge clk) sset <= 1'h1;
      @(posedge clk) sset <= 1'h0;
      @(negedge clk);
      chk("fw set", 32'h1, status);
      pulse_clr();
   endtask

   // every source code against every source, restarting on its own
   task automatic t_src();
      @(posedge clk) arst <= 1'h1;
      for (int s = 0; s < 8; s++) begin
         for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            src <= 3'(s);
            cmp1 <= (k == 0);
            cmp2 <= (k == 1);
            intp <= (k != 2);
            repeat (5) @(negedge clk);
            chk("src status", (s >> k) & 1, status);
            @(posedge clk);
            {cmp1, cmp2, intp} <= 3'h1;
            repeat (5) @(negedge clk);
            chk("auto restart", 32'h0, status);
         end
      end
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      t_flags();
      t_half(7'h02, 2'h0);
      t_half(7'h07, 2'h1);
      t_half(7'h03, 2'h2);
      t_full(1'h0, 2'h3);
      t_full(1'h1, 2'h2);
      t_dir();
      t_sd();
      t_src();
      chk("leg overlap", 32'h0, shoot);
      final_report();
   end

   // hang guard: the whole run needs about a thousand cycles of the 10000 allowed
   initial begin
      #250000;
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
